// file: srvp_top.sv
// Servo stop sequencing and overload protection with an AXI4-Lite register file.
// Assumes synchronous torque, power and motion inputs; stop pins are asynchronous.
// Summary of operation
// - Peak regeneration power is stored (1..50000 W, default 100) and used only with the external resistor.
// - Peak duration is stored (1..50000 ms, default 5000) and used only with the external resistor.
// - Overload accumulates only while torque feedback exceeds the base (10..120 %, default 100).
// - The overload warning rises when accumulation reaches the warning level (10..100 %, default 50).
// - At full accumulation the warning turns into the continuous overload alarm.
// - After servo-off the output stays enabled for the off delay (0..1000 ms, default 10).
// - The holding brake is asserted on servo-off before the output is switched off.
// - Stop mode 0..3 picks brake-then-hold, brake-then-release, free-then-release, free-then-hold.
// - Halt method 0 stops by the stop mode with short-circuit brake and zero torque.
// - Halt method 1 (default) decelerates with the halt torque.
// - Limits and halt input start the halt; torque mode never uses the deceleration stop.
// - Resistor select 1 means external resistor, 0 internal.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
module srvp_top import srvp_pkg::*; #(
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  // AXI4-Lite slave
  input wire logic [AXI_AW-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [AXI_AW-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Stop pins
  input wire logic SERVO_ON,
  input wire logic FORWARD_LIMIT_INPUT,
  input wire logic REVERSE_LIMIT_INPUT,
  input wire logic EMERGENCY_HALT_INPUT,
  // Drive feedback
  input wire logic [15:0] TORQUE_FB,
  input wire logic [15:0] REGEN_PWR,
  input wire logic TORQUE_MODE,
  input wire logic MOTOR_STOPPED,
  // Drive outputs
  output logic PWM_EN,
  output logic HOLD_BRAKE,
  output logic SHORT_CIRCUIT_BRAKE,
  output logic TORQUE_ZERO,
  output logic DECEL_STOP,
  // Protection outputs
  output logic OVERLOAD_WARNING,
  output logic CONTINUOUS_OVERLOAD_ALARM,
  output logic REGEN_OVERLOAD_ALARM
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
                                    input logic [15:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  logic tick;
  logic [3:0] pins_s;
  srvp_ms_tick #(.CYC(MS_CYCLES)) u_tick (.clk(CLK_SYS), .rst(SYS_RST), .tick(tick));
  srvp_sync2 #(.W(4)) u_sync (
    .clk(CLK_SYS), .rst(SYS_RST),
    .din({SERVO_ON, FORWARD_LIMIT_INPUT, REVERSE_LIMIT_INPUT, EMERGENCY_HALT_INPUT}),
    .dout(pins_s)
  );
  logic servo_on_s;
  logic halt_s;
  assign servo_on_s = pins_s[3];
  assign halt_s = |pins_s[2:0];

  // ----------------------------------------------------------------
  // AXI4-Lite register file
  // ----------------------------------------------------------------
  srvp_cfg_t cfg_r, cfg_nxt;
  logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [15:0] widx_r, widx_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_nxt, rvalid_nxt, awready_nxt, wready_nxt, arready_nxt;
  logic [1:0] bresp_nxt, rresp_nxt;
  logic [31:0] rdata_nxt;
  logic [2:0] clr_nxt, clr_r;
  logic [15:0] acc_r, acc_nxt;
  logic [2:0] alarm_r;
  logic [15:0] ridx;
  logic [15:0] nv;
  logic do_wr;
  // Address capture, register writes and read answers
  always_comb begin
    cfg_nxt = cfg_r;
    aw_held_nxt = aw_held_r;
    w_held_nxt = w_held_r;
    widx_nxt = widx_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = S_AXI_BVALID && !S_AXI_BREADY;
    bresp_nxt = S_AXI_BRESP;
    rvalid_nxt = S_AXI_RVALID && !S_AXI_RREADY;
    rresp_nxt = S_AXI_RRESP;
    rdata_nxt = S_AXI_RDATA;
    clr_nxt = 3'h0;
    nv = 16'h0;
    ridx = S_AXI_ARADDR[AXI_AW-1:2];
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_held_nxt = 1'b1;
      widx_nxt = S_AXI_AWADDR[AXI_AW-1:2];
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_held_nxt = 1'b1;
      wdata_nxt = S_AXI_WDATA;
      wstrb_nxt = S_AXI_WSTRB;
    end
    do_wr = aw_held_r && w_held_r && !S_AXI_BVALID;
    if (do_wr) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      // Out-of-range values are dropped and the old setting kept
      case (widx_r)
        IDX_RES_SEL: begin
          nv = merge16({15'h0, cfg_r.res_ext}, wdata_r, wstrb_r);
          if (nv <= MAX_BIT) cfg_nxt.res_ext = nv[0];
        end
        IDX_PEAK_PWR: begin
          nv = merge16(cfg_r.peak_pwr, wdata_r, wstrb_r);
          if (in_range(nv, MIN_PEAK, MAX_PEAK)) cfg_nxt.peak_pwr = nv;
        end
        IDX_PEAK_DUR: begin
          nv = merge16(cfg_r.peak_dur, wdata_r, wstrb_r);
          if (in_range(nv, MIN_PEAK, MAX_PEAK)) cfg_nxt.peak_dur = nv;
        end
        IDX_OVL_BASE: begin
          nv = merge16(cfg_r.ovl_base, wdata_r, wstrb_r);
          if (in_range(nv, MIN_BASE, MAX_BASE)) cfg_nxt.ovl_base = nv;
        end
        IDX_WARN_LVL: begin
          nv = merge16(cfg_r.warn_lvl, wdata_r, wstrb_r);
          if (in_range(nv, MIN_WARN, MAX_WARN)) cfg_nxt.warn_lvl = nv;
        end
        IDX_OFF_DLY: begin
          nv = merge16(cfg_r.off_dly, wdata_r, wstrb_r);
          if (nv <= MAX_DLY) cfg_nxt.off_dly = nv;
        end
        IDX_DB_MODE: begin
          nv = merge16({14'h0, cfg_r.db_mode}, wdata_r, wstrb_r);
          if (nv <= MAX_DB) cfg_nxt.db_mode = nv[1:0];
        end
        IDX_HALT_METH: begin
          nv = merge16({15'h0, cfg_r.halt_meth}, wdata_r, wstrb_r);
          if (nv <= MAX_BIT) cfg_nxt.halt_meth = nv[0];
        end
        IDX_STATUS: clr_nxt = wstrb_r[0] ? wdata_r[2:0] : 3'h0;
        IDX_ACCUM: bresp_nxt = RESP_OKAY;
        default: bresp_nxt = RESP_SLVERR;
      endcase
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      case (ridx)
        IDX_RES_SEL: rdata_nxt = {31'h0, cfg_r.res_ext};
        IDX_PEAK_PWR: rdata_nxt = {16'h0, cfg_r.peak_pwr};
        IDX_PEAK_DUR: rdata_nxt = {16'h0, cfg_r.peak_dur};
        IDX_OVL_BASE: rdata_nxt = {16'h0, cfg_r.ovl_base};
        IDX_WARN_LVL: rdata_nxt = {16'h0, cfg_r.warn_lvl};
        IDX_OFF_DLY: rdata_nxt = {16'h0, cfg_r.off_dly};
        IDX_DB_MODE: rdata_nxt = {30'h0, cfg_r.db_mode};
        IDX_HALT_METH: rdata_nxt = {31'h0, cfg_r.halt_meth};
        IDX_STATUS: rdata_nxt = {29'h0, alarm_r};
        IDX_ACCUM: rdata_nxt = {16'h0, acc_r};
        default: begin
          rdata_nxt = 32'h0;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
    awready_nxt = !aw_held_nxt;
    wready_nxt = !w_held_nxt;
    arready_nxt = !rvalid_nxt;
  end
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      cfg_r <= '{res_ext: RST_RES_SEL[0], peak_pwr: RST_PEAK_PWR, peak_dur: RST_PEAK_DUR,
                 ovl_base: RST_OVL_BASE, warn_lvl: RST_WARN_LVL, off_dly: RST_OFF_DLY,
                 db_mode: RST_DB_MODE[1:0], halt_meth: RST_HALT_METH[0]};
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      widx_r <= 16'h0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      clr_r <= 3'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RRESP <= RESP_OKAY;
      S_AXI_RDATA <= 32'h0;
    end else begin
      cfg_r <= cfg_nxt;
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      widx_r <= widx_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      clr_r <= clr_nxt;
      S_AXI_AWREADY <= awready_nxt;
      S_AXI_WREADY <= wready_nxt;
      S_AXI_BVALID <= bvalid_nxt;
      S_AXI_BRESP <= bresp_nxt;
      S_AXI_ARREADY <= arready_nxt;
      S_AXI_RVALID <= rvalid_nxt;
      S_AXI_RRESP <= rresp_nxt;
      S_AXI_RDATA <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Overload and regeneration protection
  // ----------------------------------------------------------------
  logic [15:0] rcnt_r, rcnt_nxt;
  logic [2:0] alarm_nxt;
  logic warn_nxt;
  logic regen_hot;
  logic [19:0] warn_pt;
  // Accumulate per ms, latch alarms; a set beats a clear in the same cycle
  always_comb begin
    acc_nxt = acc_r;
    rcnt_nxt = rcnt_r;
    regen_hot = cfg_r.res_ext && (REGEN_PWR >= cfg_r.peak_pwr);
    warn_pt = 20'(cfg_r.warn_lvl) * 20'(ACC_SCALE);
    if (tick) begin
      if (TORQUE_FB > cfg_r.ovl_base) begin
        if (acc_r < ACC_FULL) acc_nxt = acc_r + 16'h1;
      end else if (acc_r != 16'h0) begin
        acc_nxt = acc_r - 16'h1;
      end
    end
    if (!regen_hot) rcnt_nxt = 16'h0;
    else if (tick && rcnt_r != 16'hffff) rcnt_nxt = rcnt_r + 16'h1;
    alarm_nxt = alarm_r & ~clr_r;
    alarm_nxt[ST_OVL] = alarm_nxt[ST_OVL] || (acc_r >= ACC_FULL);
    alarm_nxt[ST_REGEN] = alarm_nxt[ST_REGEN] || (rcnt_r > cfg_r.peak_dur);
    warn_nxt = (20'(acc_r) >= warn_pt) && !alarm_nxt[ST_OVL];
    alarm_nxt[ST_WARN] = alarm_nxt[ST_WARN] || warn_nxt;
  end
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      acc_r <= 16'h0;
      rcnt_r <= 16'h0;
      alarm_r <= 3'h0;
      OVERLOAD_WARNING <= 1'b0;
      CONTINUOUS_OVERLOAD_ALARM <= 1'b0;
      REGEN_OVERLOAD_ALARM <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      rcnt_r <= rcnt_nxt;
      alarm_r <= alarm_nxt;
      OVERLOAD_WARNING <= warn_nxt;
      CONTINUOUS_OVERLOAD_ALARM <= alarm_nxt[ST_OVL];
      REGEN_OVERLOAD_ALARM <= alarm_nxt[ST_REGEN];
    end
  end

  // ----------------------------------------------------------------
  // Stop sequencer
  // ----------------------------------------------------------------
  srvp_state_t st_r, st_nxt;
  logic [15:0] dly_r, dly_nxt;
  srvp_drv_t drv_nxt;
  logic halt_db;
  // Next state and drive pattern
  always_comb begin
    st_nxt = st_r;
    dly_nxt = dly_r;
    halt_db = !cfg_r.halt_meth || TORQUE_MODE;
    case (st_r)
      S_RUN: begin
        dly_nxt = 16'h0;
        if (halt_s) st_nxt = halt_db ? S_STOPPING : S_DECEL;
        else if (!servo_on_s) st_nxt = S_OFFDLY;
      end
      S_OFFDLY: begin
        if (tick) dly_nxt = dly_r + 16'h1;
        if (halt_s) st_nxt = halt_db ? S_STOPPING : S_DECEL;
        else if (dly_r >= cfg_r.off_dly) st_nxt = S_STOPPING;
        else if (servo_on_s) st_nxt = S_RUN;
      end
      S_DECEL: begin
        dly_nxt = 16'h0;
        if (TORQUE_MODE) st_nxt = S_STOPPING;
        else if (!halt_s) st_nxt = servo_on_s ? S_RUN : S_OFFDLY;
      end
      S_STOPPING: if (MOTOR_STOPPED) st_nxt = S_STOPPED;
      S_STOPPED: if (servo_on_s && !halt_s) st_nxt = S_RUN;
      default: st_nxt = S_STOPPED;
    endcase
    drv_nxt = '{pwm_en: 1'b0, hold_brake: 1'b1, sc_brake: 1'b0, torque_zero: 1'b1,
                decel_stop: 1'b0};
    case (st_nxt)
      S_RUN: drv_nxt = '{pwm_en: 1'b1, hold_brake: 1'b0, sc_brake: 1'b0, torque_zero: 1'b0,
                         decel_stop: 1'b0};
      S_OFFDLY: drv_nxt.pwm_en = 1'b1;
      S_DECEL: drv_nxt = '{pwm_en: 1'b1, hold_brake: 1'b0, sc_brake: 1'b0, torque_zero: 1'b0,
                           decel_stop: 1'b1};
      S_STOPPING: drv_nxt.sc_brake = (cfg_r.db_mode == DB_BRAKE_HOLD) ||
                                     (cfg_r.db_mode == DB_BRAKE_FREE);
      S_STOPPED: drv_nxt.sc_brake = (cfg_r.db_mode == DB_BRAKE_HOLD) ||
                                    (cfg_r.db_mode == DB_RUN_HOLD);
      default: drv_nxt.pwm_en = 1'b0;
    endcase
  end
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_r <= S_STOPPED;
      dly_r <= 16'h0;
      {PWM_EN, HOLD_BRAKE, SHORT_CIRCUIT_BRAKE, TORQUE_ZERO, DECEL_STOP} <= 5'b01010;
    end else begin
      st_r <= st_nxt;
      dly_r <= dly_nxt;
      {PWM_EN, HOLD_BRAKE, SHORT_CIRCUIT_BRAKE, TORQUE_ZERO, DECEL_STOP} <= drv_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_brake_before_off: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    $fell(PWM_EN) && $past(st_r) != S_RUN && $past(st_r) != S_DECEL |-> $past(HOLD_BRAKE))
    else $error("Output switched off without brake asserted first");
  a_off_delay_hold: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    st_r == S_OFFDLY && dly_r < cfg_r.off_dly && !halt_s |=> PWM_EN)
    else $error("Output dropped before the off delay ran out");
  a_warn_level: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    OVERLOAD_WARNING |-> 20'($past(acc_r)) >= 20'($past(cfg_r.warn_lvl)) * 20'(ACC_SCALE))
    else $error("Warning raised below its level");
  a_full_alarm: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    acc_r >= ACC_FULL |=> CONTINUOUS_OVERLOAD_ALARM && !OVERLOAD_WARNING)
    else $error("Full accumulation did not turn warning into alarm");
  a_base_accum: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    tick && TORQUE_FB <= cfg_r.ovl_base |=> acc_r <= $past(acc_r))
    else $error("Accumulated at or below the base");
  a_regen_internal: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    !cfg_r.res_ext |=> rcnt_r == 16'h0)
    else $error("Peak timing ran with the internal resistor");
  a_regen_alarm: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    rcnt_r > cfg_r.peak_dur |=> REGEN_OVERLOAD_ALARM)
    else $error("Peak overrun without regen alarm");
  a_torque_no_decel: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    TORQUE_MODE && st_r == S_RUN && halt_s |=> ##1 !DECEL_STOP)
    else $error("Deceleration stop used in torque mode");
  a_halt_zero: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    st_r == S_RUN && halt_s && !cfg_r.halt_meth |=> TORQUE_ZERO && !PWM_EN)
    else $error("Method 0 halt did not zero the torque");
  a_db_hold: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    st_r == S_STOPPED && $stable(st_r) && !$past(SYS_RST) |-> SHORT_CIRCUIT_BRAKE ==
      ($past(cfg_r.db_mode) == DB_BRAKE_HOLD || $past(cfg_r.db_mode) == DB_RUN_HOLD))
    else $error("Stopped brake state does not match the stop mode");
endmodule

// file: srvp_pkg.sv
// Constants, register map and types of the servo stop and overload protection block.
// Assumes a 40 MHz system clock and an AXI4-Lite master with 32-bit data.
package srvp_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 40000000;
  localparam int TICK_MS = 1; // Accumulation and delay tick, ms
  localparam int MS_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
  localparam int AXI_AW = 18;
  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_RES_SEL = 16'h2009;
  localparam logic [15:0] IDX_PEAK_PWR = 16'h200d;
  localparam logic [15:0] IDX_PEAK_DUR = 16'h200e;
  localparam logic [15:0] IDX_OVL_BASE = 16'h200f;
  localparam logic [15:0] IDX_WARN_LVL = 16'h2010;
  localparam logic [15:0] IDX_OFF_DLY = 16'h2011;
  localparam logic [15:0] IDX_DB_MODE = 16'h2012;
  localparam logic [15:0] IDX_HALT_METH = 16'h2013;
  localparam logic [15:0] IDX_STATUS = 16'h2020;
  localparam logic [15:0] IDX_ACCUM = 16'h2021;
  // ----------------------------------------------------------------
  // Reset values and legal ranges
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_RES_SEL = 16'h0001;
  localparam logic [15:0] RST_PEAK_PWR = 16'h0064;
  localparam logic [15:0] RST_PEAK_DUR = 16'h1388;
  localparam logic [15:0] RST_OVL_BASE = 16'h0064;
  localparam logic [15:0] RST_WARN_LVL = 16'h0032;
  localparam logic [15:0] RST_OFF_DLY = 16'h000a;
  localparam logic [15:0] RST_DB_MODE = 16'h0000;
  localparam logic [15:0] RST_HALT_METH = 16'h0001;
  localparam logic [15:0] MIN_PEAK = 16'h0001;
  localparam logic [15:0] MAX_PEAK = 16'hc350;
  localparam logic [15:0] MIN_BASE = 16'h000a;
  localparam logic [15:0] MAX_BASE = 16'h0078;
  localparam logic [15:0] MIN_WARN = 16'h000a;
  localparam logic [15:0] MAX_WARN = 16'h0064;
  localparam logic [15:0] MAX_DLY = 16'h03e8;
  localparam logic [15:0] MAX_DB = 16'h0003;
  localparam logic [15:0] MAX_BIT = 16'h0001;
  // ----------------------------------------------------------------
  // Fields and codes
  // ----------------------------------------------------------------
  localparam logic [15:0] ACC_FULL = 16'h03e8; // 100.0 % in 0.1 % steps
  localparam logic [15:0] ACC_SCALE = 16'h000a;
  localparam int ST_WARN = 0;
  localparam int ST_OVL = 1;
  localparam int ST_REGEN = 2;
  localparam logic [1:0] DB_BRAKE_HOLD = 2'h0;
  localparam logic [1:0] DB_BRAKE_FREE = 2'h1;
  localparam logic [1:0] DB_RUN_FREE = 2'h2;
  localparam logic [1:0] DB_RUN_HOLD = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic res_ext;
    logic [15:0] peak_pwr;
    logic [15:0] peak_dur;
    logic [15:0] ovl_base;
    logic [15:0] warn_lvl;
    logic [15:0] off_dly;
    logic [1:0] db_mode;
    logic halt_meth;
  } srvp_cfg_t;
  typedef struct packed {
    logic pwm_en;
    logic hold_brake;
    logic sc_brake;
    logic torque_zero;
    logic decel_stop;
  } srvp_drv_t;
  typedef enum logic [2:0] {
    S_RUN = 3'b000,
    S_OFFDLY = 3'b001,
    S_STOPPING = 3'b010,
    S_STOPPED = 3'b011,
    S_DECEL = 3'b100
  } srvp_state_t;
endpackage

// file: srvp_sync2.sv
// Two-flop synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to CLK_SYS.
`timescale 1ns/100ps
module srvp_sync2 #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] dout_nxt;
  // Shift chain; first stage feeds only the second
  always_comb begin
    meta_nxt = din;
    dout_nxt = meta_r;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      dout <= '0;
    end else begin
      meta_r <= meta_nxt;
      dout <= dout_nxt;
    end
  end
endmodule

// file: srvp_ms_tick.sv
// Millisecond tick generator: one-cycle pulse every CYC clocks.
// Assumes a free-running system clock.
`timescale 1ns/100ps
module srvp_ms_tick #(
  parameter int CYC = 40000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Tick
  output logic tick
);
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic tick_nxt;
  // Count down and pulse at wrap
  always_comb begin
    tick_nxt = (cnt_r == 32'h0);
    cnt_nxt = tick_nxt ? 32'(CYC - 1) : cnt_r - 32'h1;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      tick <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick <= tick_nxt;
    end
  end
endmodule

// file: srvp_host.sv
// Host model on the register bus: one write and one read at a time.
// Assumes the slave answers within 200 clocks; tmo marks a wait that ran out.
`timescale 1ns/100ps
module srvp_host import srvp_pkg::*; (
  // Clock
  input wire logic CLK_SYS,
  // Write channels
  output logic [AXI_AW-1:0] S_AXI_AWADDR,
  output logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  output logic [31:0] S_AXI_WDATA,
  output logic [3:0] S_AXI_WSTRB,
  output logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  output logic S_AXI_BREADY,
  // Read channels
  output logic [AXI_AW-1:0] S_AXI_ARADDR,
  output logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  output logic S_AXI_RREADY
);
  bit tmo = 0;
  // Idle bus at time zero
  initial begin
    {S_AXI_AWADDR, S_AXI_AWVALID, S_AXI_WDATA, S_AXI_WVALID, S_AXI_BREADY} = '0;
    {S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY} = '0;
    S_AXI_WSTRB = 4'hf;
  end
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [15:0] ix, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge CLK_SYS);
    S_AXI_AWADDR <= {ix, 2'b00};
    S_AXI_WDATA <= d;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'b111;
    for (n = 0; n < 200 && !(S_AXI_BVALID && S_AXI_BREADY); n++) begin
      @(posedge CLK_SYS);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end
    r = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
    tmo |= n == 200;
  endtask
  // Read one word; data taken at the edge where rvalid is seen
  task automatic rd(input logic [15:0] ix, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge CLK_SYS);
    S_AXI_ARADDR <= {ix, 2'b00};
    {S_AXI_ARVALID, S_AXI_RREADY} <= 2'b11;
    for (n = 0; n < 200 && !(S_AXI_RVALID && S_AXI_RREADY); n++) begin
      @(posedge CLK_SYS);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end
    {d, r} = {S_AXI_RDATA, S_AXI_RRESP};
    S_AXI_RREADY <= 1'b0;
    tmo |= n == 200;
  endtask
endmodule

// file: testbench.sv
// Self-checking bench for the servo stop and overload protection block.
// Assumes the host model drives the bus; one millisecond is 8 clocks here.
`timescale 1ns/100ps
module testbench import srvp_pkg::*; ;
  logic CLK_SYS = 0, SYS_RST = 1, SERVO_ON = 0, FORWARD_LIMIT_INPUT = 0;
  logic REVERSE_LIMIT_INPUT = 0, EMERGENCY_HALT_INPUT = 0, TORQUE_MODE = 0, MOTOR_STOPPED = 1;
  logic [15:0] TORQUE_FB = 0, REGEN_PWR = 0;
  logic [AXI_AW-1:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rd_d;
  logic [3:0] S_AXI_WSTRB;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rsp;
  logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
  logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY, PWM_EN, HOLD_BRAKE;
  logic SHORT_CIRCUIT_BRAKE, TORQUE_ZERO, DECEL_STOP, OVERLOAD_WARNING;
  logic CONTINUOUS_OVERLOAD_ALARM, REGEN_OVERLOAD_ALARM;
  int error_cnt = 0, total_checks = 0, n;
  srvp_top #(.MS_CYCLES(8)) dut (.*);
  srvp_host host (.*);
  initial forever #12.5 CLK_SYS = ~CLK_SYS;
  // ----------------------------------------------------------------
  // Checking and bus helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic hang(input string nm);
    chk(nm, 0, 1);
    report_and_stop;
  endtask
  // Bounded wait for a level; n holds the cycles spent
  task automatic wt(ref logic s, input logic v, input int lim);
    for (n = 0; n < lim && s !== v; n++) @(posedge CLK_SYS);
    if (n == lim) hang("wait");
  endtask
  task automatic wc(input logic [15:0] ix, input logic [31:0] d);
    host.wr(ix, d, rsp);
    if (host.tmo) hang("bus");
  endtask
  task automatic rc(input logic [15:0] ix, input logic [31:0] e, input logic [1:0] er);
    host.rd(ix, rd_d, rsp);
    if (host.tmo) hang("bus");
    chk("rdata", rd_d, e);
    chk("rresp", rsp, er);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    logic [15:0] ix [8] = '{IDX_RES_SEL, IDX_PEAK_PWR, IDX_PEAK_DUR, IDX_OVL_BASE,
      IDX_WARN_LVL, IDX_OFF_DLY, IDX_DB_MODE, IDX_HALT_METH};
    logic [15:0] rv [8] = '{RST_RES_SEL, RST_PEAK_PWR, RST_PEAK_DUR, RST_OVL_BASE,
      RST_WARN_LVL, RST_OFF_DLY, RST_DB_MODE, RST_HALT_METH};
    for (int i = 0; i < 8; i++) rc(ix[i], {16'h0, rv[i]}, RESP_OKAY);
    rc(16'h2030, 32'h0, RESP_SLVERR);
    wc(16'h2030, 32'h0);
    chk("bresp_unmapped", rsp, RESP_SLVERR);
    wc(IDX_PEAK_PWR, 32'h0);
    chk("bresp", rsp, RESP_OKAY);
    rc(IDX_PEAK_PWR, {16'h0, RST_PEAK_PWR}, RESP_OKAY);
    wc(IDX_PEAK_DUR, {16'h0, MAX_PEAK});
    rc(IDX_PEAK_DUR, {16'h0, MAX_PEAK}, RESP_OKAY);
    $display("registers done");
  endtask
  task automatic t_stop;
    wc(IDX_OFF_DLY, 32'h3);
    for (int m = 0; m < 4; m++) begin
      wc(IDX_DB_MODE, m);
      MOTOR_STOPPED <= 1'b0;
      SERVO_ON <= 1'b1;
      wt(PWM_EN, 1'b1, 40);
      chk("brake_run", HOLD_BRAKE, 0);
      SERVO_ON <= 1'b0;
      wt(HOLD_BRAKE, 1'b1, 10);
      chk("pwm_with_brake", PWM_EN, 1);
      wt(PWM_EN, 1'b0, 40);
      chk("off_delay", n >= 15 && n <= 25, 1);
      chk("db_stopping", SHORT_CIRCUIT_BRAKE, m < 2);
      MOTOR_STOPPED <= 1'b1;
      repeat (4) @(posedge CLK_SYS);
      chk("db_stopped", SHORT_CIRCUIT_BRAKE, m == 0 || m == 3);
    end
    $display("stop modes done");
  endtask
  task automatic t_halt;
    wc(IDX_DB_MODE, 32'h0);
    for (int k = 0; k < 3; k++) begin
      wc(IDX_HALT_METH, k != 0);
      TORQUE_MODE <= k == 2;
      SERVO_ON <= 1'b1;
      wt(PWM_EN, 1'b1, 40);
      {EMERGENCY_HALT_INPUT, REVERSE_LIMIT_INPUT, FORWARD_LIMIT_INPUT} <= 3'b001 << k;
      if (k == 1) begin
        wt(DECEL_STOP, 1'b1, 20);
        chk("decel_pwm", PWM_EN, 1);
      end else begin
        wt(TORQUE_ZERO, 1'b1, 20);
        chk("halt_db", {PWM_EN, SHORT_CIRCUIT_BRAKE, DECEL_STOP}, 3'b010);
      end
      {EMERGENCY_HALT_INPUT, REVERSE_LIMIT_INPUT, FORWARD_LIMIT_INPUT} <= 3'b000;
      SERVO_ON <= 1'b0;
      wt(PWM_EN, 1'b0, 60);
    end
    TORQUE_MODE <= 1'b0;
    $display("halt done");
  endtask
  task automatic t_ovl;
    wc(IDX_OVL_BASE, {16'h0, MIN_BASE});
    wc(IDX_WARN_LVL, {16'h0, MIN_WARN});
    TORQUE_FB <= 16'd10;
    repeat (400) @(posedge CLK_SYS);
    rc(IDX_ACCUM, 32'h0, RESP_OKAY);
    TORQUE_FB <= 16'd11;
    wt(OVERLOAD_WARNING, 1'b1, 1000);
    chk("warn_time", n >= 790 && n <= 815, 1);
    chk("alarm_early", CONTINUOUS_OVERLOAD_ALARM, 0);
    wt(CONTINUOUS_OVERLOAD_ALARM, 1'b1, 8000);
    chk("warn_to_alarm", {OVERLOAD_WARNING, n >= 7100}, 2'b01);
    TORQUE_FB <= 16'd0;
    $display("overload done");
  endtask
  task automatic t_regen;
    wc(IDX_PEAK_PWR, 32'd200);
    wc(IDX_PEAK_DUR, 32'd5);
    wc(IDX_RES_SEL, 32'h0);
    REGEN_PWR <= 16'd200;
    repeat (100) @(posedge CLK_SYS);
    chk("regen_internal", REGEN_OVERLOAD_ALARM, 0);
    wc(IDX_RES_SEL, 32'h1);
    wt(REGEN_OVERLOAD_ALARM, 1'b1, 80);
    chk("regen_delay", n >= 36 && n <= 60, 1);
    rc(IDX_STATUS, 32'h7, RESP_OKAY);
    wc(IDX_STATUS, 32'h7);
    rc(IDX_STATUS, 32'h5, RESP_OKAY);
    chk("alarm_clr", {CONTINUOUS_OVERLOAD_ALARM, OVERLOAD_WARNING, REGEN_OVERLOAD_ALARM}, 3'b011);
    $display("regen done");
  endtask
  // Reset, then every scenario in turn
  initial begin
    repeat (20) @(posedge CLK_SYS);
    SYS_RST <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    t_regs;
    t_stop;
    t_halt;
    t_ovl;
    t_regen;
    report_and_stop;
  end
endmodule
